// >>> rtl/modem_ctl_cfg.svh
// constants of the modem control, loopback and baud divisor block
// assumes inclusion by bare name from the design file
`ifndef MODEM_CTL_CFG_SVH
`define MODEM_CTL_CFG_SVH
`define ADDR_W          3
`define OFF_DIV_LO      3'h0
`define OFF_DIV_HI      3'h1
`define OFF_LINE_CTRL   3'h3
`define OFF_MODEM_CTRL  3'h4
`define OFF_MODEM_STAT  3'h6
`define OFF_INT_ENABLE  3'h1
`define BIT_TERM_READY  0
`define BIT_REQ_SEND    1
`define BIT_USER_ONE    2
`define BIT_USER_TWO    3
`define BIT_LOOPBACK    4
`define BIT_DIV_ACCESS  7
`define BIT_MS_INT_EN   3
`define RST_DIVISOR     16'h0001
`define RST_MODEM_CTRL  8'h00
`define RST_LINE_CTRL   8'h00
`define RST_INT_ENABLE  8'h00
`endif

// >>> rtl/modem_ctl_pkg.sv
// types of the modem control block
// assumes nothing beyond the config header
package modem_ctl_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] divisor_t;
  typedef enum logic [1:0] {LINES_IDLE, LINES_LOOP} path_t;
endpackage

// >>> rtl/modem_ctl.sv
// modem control, local loopback, modem status and baud divisor
// assumes a synchronous register port and synchronous pins
//
// Contract
// - control bit 3 set drives user output two low, clear drives high.
// - control bit 0 set drives terminal-ready low, clear drives high.
// - in loopback the serial output pin is held high.
// - in loopback serial input ignored; transmitter output feeds receiver input.
// - in loopback modem inputs are replaced internally by the output controls.
// - in loopback all four modem output pins are driven high.
// - in loopback modem status interrupt sources come from control bits 0-3.
// - control bits 5 to 7 always read zero.
// - reading modem status clears the four change flags.
// - status bit 0 flags a clear-to-send change since last read.
// - status bit 1 flags a data-set-ready change since last read.
// - status bit 2 flags ring going low to high only.
// - status bit 3 flags a carrier-detect change since last read.
// - modem interrupt when any change flag set and interrupt enabled.
// - status bits 4-7 are complemented cts, dsr, ring, dcd inputs.
// - in loopback status bits 4-7 equal rts, dtr, user one, user two.
// - divide reference clock by divisor 1 to 65535 into 16x pulses.
// - divisor is held as 16 bits in two 8-bit latches.
// - writing either divisor latch reloads the baud counter at once.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ns
`include "modem_ctl_cfg.svh"

module modem_ctl
(
  input  wire logic               CLK_I,
  input  wire logic               SRST_I,
  input  wire logic               CE_I,
  input  wire logic [2:0]         ADDR_I,
  input  wire logic [7:0]         WDATA_I,
  input  wire logic               WR_I,
  input  wire logic               RD_I,
  output logic      [7:0]         RDATA_O,
  input  wire logic               CTS_N_I,
  input  wire logic               DSR_N_I,
  input  wire logic               RING_N_I,
  input  wire logic               DCD_N_I,
  output logic                    TERM_READY_N_O,
  output logic                    REQ_SEND_N_O,
  output logic                    USER_OUTPUT_ONE_N_O,
  output logic                    USER_OUTPUT_TWO_N_O,
  input  wire logic               TX_SHIFT_OUT_I,
  input  wire logic               SERIAL_INPUT_PIN_I,
  output logic                    SERIAL_OUTPUT_PIN_O,
  output logic                    RX_SHIFT_IN_O,
  output logic                    BAUD16_O,
  output logic                    MODEM_INT_O
);

  modem_ctl_pkg::byte_t    modem_output_control;
  modem_ctl_pkg::byte_t    line_control;
  modem_ctl_pkg::byte_t    interrupt_enable_register;
  modem_ctl_pkg::divisor_t divisor;
  modem_ctl_pkg::divisor_t baud_count;
  logic [3:0]              change_flags;
  logic [3:0]              lines;
  logic [3:0]              lines_q;
  logic                    lines_valid;
  logic [3:0]              next_flags;
  logic                    loop_on;
  logic                    dl_access;
  modem_ctl_pkg::path_t    path;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
    hit = (a == off);
  endfunction

  assign loop_on   = modem_output_control[`BIT_LOOPBACK];
  assign dl_access = line_control[`BIT_DIV_ACCESS];
  assign path      = loop_on ? modem_ctl_pkg::LINES_LOOP : modem_ctl_pkg::LINES_IDLE;

  ////////////////////////////////////////////////////////////////////////
  // register writes

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      line_control <= `RST_LINE_CTRL;
    else if (CE_I && WR_I && hit(ADDR_I, `OFF_LINE_CTRL))
      line_control <= WDATA_I;
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      modem_output_control <= `RST_MODEM_CTRL;
    else if (CE_I && WR_I && hit(ADDR_I, `OFF_MODEM_CTRL))
      modem_output_control <= {3'h0, WDATA_I[4:0]};
  end

  // interrupt enable shares its slot with the high divisor latch
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      interrupt_enable_register <= `RST_INT_ENABLE;
    else if (CE_I && WR_I && !dl_access && hit(ADDR_I, `OFF_INT_ENABLE))
      interrupt_enable_register <= WDATA_I;
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      divisor <= `RST_DIVISOR;
    else if (CE_I && WR_I && dl_access && hit(ADDR_I, `OFF_DIV_LO))
      divisor[7:0] <= WDATA_I;
    else if (CE_I && WR_I && dl_access && hit(ADDR_I, `OFF_DIV_HI))
      divisor[15:8] <= WDATA_I;
  end

  ////////////////////////////////////////////////////////////////////////
  // baud counter: counts down to one, then pulses and reloads.
  // divisor zero is treated as one so the output never stalls

  logic div_write;
  assign div_write = WR_I && dl_access && (hit(ADDR_I, `OFF_DIV_LO) || hit(ADDR_I, `OFF_DIV_HI));

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      baud_count <= `RST_DIVISOR;
      BAUD16_O   <= 1'b0;
    end
    else if (CE_I)
    begin
      if (div_write)
      begin
        // new value is taken whole, not the half being replaced
        baud_count <= hit(ADDR_I, `OFF_DIV_LO) ? {divisor[15:8], WDATA_I} : {WDATA_I, divisor[7:0]};
        BAUD16_O   <= 1'b0;
      end
      else if (baud_count <= 16'h0001)
      begin
        baud_count <= divisor;
        BAUD16_O   <= 1'b1;
      end
      else
      begin
        baud_count <= baud_count - 16'h0001;
        BAUD16_O   <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // modem lines, active-high meaning: cts, dsr, ring, dcd

  always_comb
  begin
    case (path)
      modem_ctl_pkg::LINES_LOOP:
        lines = {modem_output_control[`BIT_USER_TWO], modem_output_control[`BIT_USER_ONE],
                 modem_output_control[`BIT_TERM_READY], modem_output_control[`BIT_REQ_SEND]};
      default:
        lines = {~DCD_N_I, ~RING_N_I, ~DSR_N_I, ~CTS_N_I};
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      lines_q     <= 4'h0;
      lines_valid <= 1'b0;
    end
    else if (CE_I)
    begin
      lines_q     <= lines;
      lines_valid <= 1'b1;
    end
  end

  always_comb
  begin
    next_flags = change_flags;
    if (CE_I && RD_I && hit(ADDR_I, `OFF_MODEM_STAT))
      next_flags = 4'h0;
    if (lines_valid)
    begin
      next_flags[0] = next_flags[0] | (lines[0] ^ lines_q[0]);
      next_flags[1] = next_flags[1] | (lines[1] ^ lines_q[1]);
      // ring pin low-to-high is the asserted level falling
      next_flags[2] = next_flags[2] | (lines_q[2] & ~lines[2]);
      next_flags[3] = next_flags[3] | (lines[3] ^ lines_q[3]);
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      change_flags <= 4'h0;
    else if (CE_I)
      change_flags <= next_flags;
  end

  assign MODEM_INT_O = (|change_flags) & interrupt_enable_register[`BIT_MS_INT_EN];

  ////////////////////////////////////////////////////////////////////////
  // pins

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      TERM_READY_N_O      <= 1'b1;
      REQ_SEND_N_O        <= 1'b1;
      USER_OUTPUT_ONE_N_O <= 1'b1;
      USER_OUTPUT_TWO_N_O <= 1'b1;
    end
    else if (CE_I)
    begin
      TERM_READY_N_O      <= loop_on | ~modem_output_control[`BIT_TERM_READY];
      REQ_SEND_N_O        <= loop_on | ~modem_output_control[`BIT_REQ_SEND];
      USER_OUTPUT_ONE_N_O <= loop_on | ~modem_output_control[`BIT_USER_ONE];
      USER_OUTPUT_TWO_N_O <= loop_on | ~modem_output_control[`BIT_USER_TWO];
    end
  end

  // serial path is combinational so bit timing is untouched
  assign SERIAL_OUTPUT_PIN_O = loop_on ? 1'b1 : TX_SHIFT_OUT_I;
  assign RX_SHIFT_IN_O       = loop_on ? TX_SHIFT_OUT_I : SERIAL_INPUT_PIN_I;

  ////////////////////////////////////////////////////////////////////////
  // read port, data in the cycle after the strobe

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      RDATA_O <= 8'h00;
    else if (CE_I && RD_I)
    begin
      if (dl_access && hit(ADDR_I, `OFF_DIV_LO))
        RDATA_O <= divisor[7:0];
      else if (dl_access && hit(ADDR_I, `OFF_DIV_HI))
        RDATA_O <= divisor[15:8];
      else if (hit(ADDR_I, `OFF_INT_ENABLE))
        RDATA_O <= interrupt_enable_register;
      else if (hit(ADDR_I, `OFF_LINE_CTRL))
        RDATA_O <= line_control;
      else if (hit(ADDR_I, `OFF_MODEM_CTRL))
        RDATA_O <= {3'h0, modem_output_control[4:0]};
      else if (hit(ADDR_I, `OFF_MODEM_STAT))
        RDATA_O <= {lines, change_flags};
      else
        RDATA_O <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_ctrl_high_zero: assert property (@(posedge CLK_I) disable iff (SRST_I)
    modem_output_control[7:5] == 3'h0) else $error("control high bits not zero");

  a_loop_pins_high: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && loop_on |=> (TERM_READY_N_O && REQ_SEND_N_O && USER_OUTPUT_ONE_N_O && USER_OUTPUT_TWO_N_O))
    else $error("modem pins not high in loopback");

  a_dtr_follows: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && !loop_on && modem_output_control[0] |=> !TERM_READY_N_O) else $error("terminal ready not low");

  a_user_two_follows: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && !loop_on && !modem_output_control[3] |=> USER_OUTPUT_TWO_N_O) else $error("user two not high");

  a_serial_out_loop: assert property (@(posedge CLK_I) disable iff (SRST_I)
    loop_on |-> SERIAL_OUTPUT_PIN_O && (RX_SHIFT_IN_O == TX_SHIFT_OUT_I)) else $error("loopback serial path");

  a_status_read_clear: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && RD_I && hit(ADDR_I, `OFF_MODEM_STAT) && (lines == lines_q) |=> change_flags == 4'h0)
    else $error("change flags not cleared by read");

  a_cts_change: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && lines_valid && (lines[0] != lines_q[0]) |=> change_flags[0]) else $error("cts change lost");

  a_ring_trail: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && lines_valid && lines[2] && !lines_q[2] && !change_flags[2] && !RD_I |=> !change_flags[2])
    else $error("ring leading edge flagged");

  a_int_gate: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && lines_valid && (lines[3] != lines_q[3]) |=> MODEM_INT_O == interrupt_enable_register[`BIT_MS_INT_EN])
    else $error("modem interrupt gating");

  a_baud_reload: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && div_write |=> !BAUD16_O ##0 baud_count == divisor) else $error("divisor write did not reload");

  a_dsr_change: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && lines_valid && (lines[1] != lines_q[1]) |=> change_flags[1])
    else $error("dsr change lost");

  a_dcd_change: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && lines_valid && (lines[3] != lines_q[3]) |=> change_flags[3])
    else $error("dcd change lost");

  a_ring_trail_set: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && lines_valid && lines_q[2] && !lines[2] |=> change_flags[2])
    else $error("ring trailing edge lost");

  a_status_pins: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && RD_I && !loop_on && hit(ADDR_I, `OFF_MODEM_STAT)
    |=> RDATA_O[7:4] == ~{$past(DCD_N_I), $past(RING_N_I), $past(DSR_N_I), $past(CTS_N_I)})
    else $error("status levels not complemented pins");

  a_status_loop: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && RD_I && loop_on && hit(ADDR_I, `OFF_MODEM_STAT)
    |=> RDATA_O[7:4] == {$past(modem_output_control[`BIT_USER_TWO]), $past(modem_output_control[`BIT_USER_ONE]),
                         $past(modem_output_control[`BIT_TERM_READY]), $past(modem_output_control[`BIT_REQ_SEND])})
    else $error("loopback status bits");

  a_user_pins_follow: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && !loop_on
    |=> (REQ_SEND_N_O == ~$past(modem_output_control[`BIT_REQ_SEND]))
        && (USER_OUTPUT_ONE_N_O == ~$past(modem_output_control[`BIT_USER_ONE])))
    else $error("request or user one pin level");

  a_div_low: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && WR_I && dl_access && hit(ADDR_I, `OFF_DIV_LO) |=> divisor[7:0] == $past(WDATA_I))
    else $error("divisor low latch");

  a_div_high: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && WR_I && dl_access && hit(ADDR_I, `OFF_DIV_HI) |=> divisor[15:8] == $past(WDATA_I))
    else $error("divisor high latch");

  // clock enable low must leave every register where it was
  a_ce_freeze: assert property (@(posedge CLK_I) disable iff (SRST_I)
    !CE_I |=> $stable(modem_output_control) && $stable(divisor) && $stable(change_flags) && $stable(baud_count))
    else $error("state moved with clock enable low");

  ////////////////////////////////////////////////////////////////////////
  // pulse spacing helper: cycles since the last pulse, forgotten on a reload

  logic [15:0] since_pulse;
  logic        period_known;

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      since_pulse  <= 16'h0000;
      period_known <= 1'b0;
    end
    else if (CE_I && div_write)
    begin
      since_pulse  <= 16'h0000;
      period_known <= 1'b0;
    end
    else if (CE_I && BAUD16_O)
    begin
      since_pulse  <= 16'h0001;
      period_known <= 1'b1;
    end
    else if (CE_I)
      since_pulse <= since_pulse + 16'h0001;
  end

  a_baud_period: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && period_known && BAUD16_O |-> since_pulse == ((divisor == 16'h0000) ? 16'h0001 : divisor))
    else $error("baud pulse spacing");

  c_loop_entered: cover property (@(posedge CLK_I) disable iff (SRST_I) $rose(loop_on));
  c_ring_flag:    cover property (@(posedge CLK_I) disable iff (SRST_I) $rose(change_flags[2]));
  c_baud_pulse:   cover property (@(posedge CLK_I) disable iff (SRST_I) BAUD16_O ##1 !BAUD16_O);
  c_int_raised:   cover property (@(posedge CLK_I) disable iff (SRST_I) $rose(MODEM_INT_O));
  c_read_clears:  cover property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && RD_I && hit(ADDR_I, `OFF_MODEM_STAT) && (|change_flags));

endmodule

// >>> dv/modem_far_end.sv
// far-end data set model driving the four handshake lines
// assumes the bench picks levels as {dcd, ring, dsr, cts}, active low
`timescale 1ns/1ns
module modem_far_end
(
  input  wire logic       clk_i,
  input  wire logic [3:0] want_i,
  output logic      [3:0] lines_n_o
);
  logic [3:0] lines = 4'hf;
  ////////////////////////////////////////////////////////////////////////
  // lines move just after an edge, as a synchronous data set would
  always @(posedge clk_i)
    lines <= want_i;
  assign lines_n_o = lines;
endmodule

// >>> dv/tb.sv
// self-checking bench for the modem control, loopback and baud block
// assumes modem_ctl and the far-end model modem_far_end
`timescale 1ns/1ns
module tb;
  logic                 CLK_I, SRST_I, WR_I, RD_I, TX_SHIFT_OUT_I, SERIAL_INPUT_PIN_I;
  logic                 SERIAL_OUTPUT_PIN_O, RX_SHIFT_IN_O, BAUD16_O, MODEM_INT_O;
  logic [2:0]           ADDR_I;
  logic                 CE_I;
  logic [3:0]           want, lines_n;
  wire  [3:0]           pins_n;
  modem_ctl_pkg::byte_t WDATA_I, RDATA_O, v;
  int                   bad_count = 0, compares = 0, f, s;
  typedef struct {modem_ctl_pkg::byte_t w; logic [3:0] p; modem_ctl_pkg::byte_t r;} row_t;
  row_t rows [6] = '{'{8'h01, 4'he, 8'h01}, '{8'h02, 4'hd, 8'h02}, '{8'h04, 4'hb, 8'h04},
                     '{8'h08, 4'h7, 8'h08}, '{8'he3, 4'hc, 8'h03}, '{8'h1f, 4'hf, 8'h1f}};
  modem_ctl u_modem_ctl (.CLK_I(CLK_I), .SRST_I(SRST_I), .CE_I(CE_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .CTS_N_I(lines_n[0]),
    .DSR_N_I(lines_n[1]), .RING_N_I(lines_n[2]), .DCD_N_I(lines_n[3]), .TERM_READY_N_O(pins_n[0]),
    .REQ_SEND_N_O(pins_n[1]), .USER_OUTPUT_ONE_N_O(pins_n[2]), .USER_OUTPUT_TWO_N_O(pins_n[3]),
    .TX_SHIFT_OUT_I(TX_SHIFT_OUT_I), .SERIAL_INPUT_PIN_I(SERIAL_INPUT_PIN_I),
    .SERIAL_OUTPUT_PIN_O(SERIAL_OUTPUT_PIN_O), .RX_SHIFT_IN_O(RX_SHIFT_IN_O),
    .BAUD16_O(BAUD16_O), .MODEM_INT_O(MODEM_INT_O));
  modem_far_end u_modem_far_end (.clk_i(CLK_I), .want_i(want), .lines_n_o(lines_n));
  initial
  begin
    CLK_I = 0;
    forever #10 CLK_I = ~CLK_I;
  end
  ////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input modem_ctl_pkg::byte_t e, input modem_ctl_pkg::byte_t g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [2:0] a, input modem_ctl_pkg::byte_t d);
    @(posedge CLK_I);
    WR_I <= 1'b1;
    ADDR_I <= a;
    WDATA_I <= d;
    @(posedge CLK_I);
    WR_I <= 1'b0;
  endtask
  // read data appear in the cycle after the strobe and hold until the next read
  task rd(input logic [2:0] a);
    @(posedge CLK_I);
    RD_I <= 1'b1;
    ADDR_I <= a;
    @(posedge CLK_I);
    RD_I <= 1'b0;
    #1 v = RDATA_O;
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // f: cycles to first pulse, s: cycles from that pulse to the next
  task spacing;
    @(negedge CLK_I);
    for (f = 0; f < 300 && BAUD16_O !== 1'b1; f++) @(negedge CLK_I);
    s = 0;
    do
    begin
      @(negedge CLK_I);
      s++;
    end
    while (BAUD16_O !== 1'b1 && s < 300);
    if (f >= 300 || s >= 300)
    begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    SRST_I = 1;
    CE_I = 1;
    WR_I = 0;
    RD_I = 0;
    ADDR_I = 0;
    WDATA_I = 0;
    TX_SHIFT_OUT_I = 0;
    SERIAL_INPUT_PIN_I = 1;
    want = 4'hf;
    repeat (12) @(posedge CLK_I);
    SRST_I <= 0;
    rd(4); chk("ctrl reset", 8'h00, v);
    rd(6); chk("status reset", 8'h00, v);
    chk("pins reset", 8'h0f, {4'h0, pins_n});
    foreach (rows[r])
    begin
      wr(4, rows[r].w);
      rd(4); chk("ctrl", rows[r].r, v);
      chk("pins", {4'h0, rows[r].p}, {4'h0, pins_n});
    end
    wr(4, 8'h00);
    rd(6);
    wr(1, 8'h08);
    for (int i = 0; i < 4; i++)
    begin
      want[i] <= 1'b0;
      repeat (5) @(posedge CLK_I);
      chk("int", {7'h0, i != 2}, {7'h0, MODEM_INT_O});
      rd(6); chk("status", (8'h10 << i) | (i == 2 ? 8'h00 : 8'h01 << i), v);
      chk("int cleared", 8'h00, {7'h0, MODEM_INT_O});
      want[i] <= 1'b1;
      repeat (5) @(posedge CLK_I);
      rd(6); chk("status off", 8'h01 << i, v);
    end
    // masked: flag set but no interrupt
    wr(1, 8'h00);
    want[0] <= 1'b0;
    repeat (5) @(posedge CLK_I);
    chk("int masked", 8'h00, {7'h0, MODEM_INT_O});
    want[0] <= 1'b1;
    repeat (5) @(posedge CLK_I);
    rd(6); chk("status twice", 8'h01, v);
    wr(1, 8'h08);
    wr(4, 8'h1a);
    want[1] <= 1'b0;
    repeat (5) @(posedge CLK_I);
    chk("loop pins", 8'h0f, {4'h0, pins_n});
    chk("loop int", 8'h01, {7'h0, MODEM_INT_O});
    rd(6); chk("loop status", 8'h99, v);
    TX_SHIFT_OUT_I <= 1'b1;
    SERIAL_INPUT_PIN_I <= 1'b0;
    @(negedge CLK_I);
    chk("loop serial", 8'h03, {6'h0, SERIAL_OUTPUT_PIN_O, RX_SHIFT_IN_O});
    TX_SHIFT_OUT_I <= 1'b0;
    @(negedge CLK_I);
    chk("loop serial", 8'h02, {6'h0, SERIAL_OUTPUT_PIN_O, RX_SHIFT_IN_O});
    wr(4, 8'h00);
    SERIAL_INPUT_PIN_I <= 1'b1;
    @(negedge CLK_I);
    chk("serial", 8'h01, {6'h0, SERIAL_OUTPUT_PIN_O, RX_SHIFT_IN_O});
    // clock enable low: the strobe is ignored and nothing moves
    CE_I <= 1'b0;
    wr(4, 8'h01);
    CE_I <= 1'b1;
    rd(4); chk("frozen ctrl", 8'h00, v);
    chk("frozen pins", 8'h0f, {4'h0, pins_n});
    want[1] <= 1'b1;
    wr(7, 8'hff);
    rd(7); chk("unmapped", 8'h00, v);
    rd(5); chk("unmapped", 8'h00, v);
    wr(3, 8'h80);
    wr(0, 8'h02);
    wr(1, 8'h01);
    spacing(); chk("baud 258", 8'h02, s[7:0] ^ 8'h00);
    chk("baud 258 high", 8'h01, s[15:8]);
    rd(0); chk("div low", 8'h02, v);
    rd(1); chk("div high", 8'h01, v);
    wr(1, 8'h00);
    spacing(); chk("reload", 8'h01, {7'h0, f <= 4});
    chk("baud 2", 8'h02, s[7:0]);
    wr(0, 8'h01);
    spacing(); chk("baud 1", 8'h01, s[7:0]);
    wr(3, 8'h00);
    rd(0); chk("div hidden", 8'h00, v);
    rd(1); chk("int enable", 8'h08, v);
    // second reset in mid-run, with state set beforehand
    wr(4, 8'h03);
    SRST_I <= 1'b1;
    @(posedge CLK_I);
    SRST_I <= 1'b0;
    rd(4); chk("ctrl re-reset", 8'h00, v);
    chk("pins re-reset", 8'h0f, {4'h0, pins_n});
    chk("int re-reset", 8'h00, {7'h0, MODEM_INT_O});
    rd(1); chk("int enable re-reset", 8'h00, v);
    wr(3, 8'h80);
    rd(0); chk("div re-reset", 8'h01, v);
    tally_and_finish();
  end
endmodule
